/* File: inc/scan_pkg.sv */
// Shared constants and types for the boundary-scan instruction decode block.
package scan_pkg;
  localparam int IR_W = 5;
  typedef logic [IR_W-1:0] instr_t;
  localparam instr_t INS_EXTEST = 5'h00;
  localparam instr_t INS_SAMPLE = 5'h01;
  localparam instr_t INS_USER_A = 5'h02;
  localparam instr_t INS_USER_B = 5'h03;
  localparam instr_t INS_CFG_OUT = 5'h04;
  localparam instr_t INS_CFG_IN = 5'h05;
  localparam instr_t INS_INTEST = 5'h07;
  localparam instr_t INS_USERCODE = 5'h08;
  localparam instr_t INS_IDCODE = 5'h09;
  localparam instr_t INS_HIGHZ = 5'h0a;
  localparam instr_t INS_STARTUP = 5'h0c;
  localparam instr_t INS_BYPASS = 5'h1f;
  // Fixed pattern loaded into the instruction shifter on capture.
  localparam instr_t IR_CAPTURE = 5'h01;
  // Identification word; the value is arbitrary, bit 0 must stay set.
  localparam logic [31:0] ID_VALUE = 32'h0a5c_3001;
  localparam int ID_W = 32;
  localparam int IO_BLOCKS = 4;
  localparam int CELLS_PER_IO = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] STARTUP_LAST = 3'h7;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;
  typedef enum logic [1:0] {CFG_BLANK, CFG_LOADING, CFG_READY} cfg_phase_t;
endpackage

/* File: src/scan_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for levels and toggles entering a clock domain.
module scan_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;
  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state.meta = async_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  assign sync_out = state_ff.stable;
endmodule

/* File: src/scan_io_cells.sv */
`timescale 1ns/10ps
// Boundary cells of one io_block: capture, shift and update stages.
module scan_io_cells
  import scan_pkg::*;
(
  input wire logic tck,
  input wire logic tck_rst,
  input wire logic capture_en,
  input wire logic shift_en,
  input wire logic update_en,
  input wire logic scan_in,
  input wire logic [CELLS_PER_IO-1:0] cap_val,
  output logic scan_out,
  output logic [CELLS_PER_IO-1:0] upd_val
);
  typedef struct packed {
    logic [CELLS_PER_IO-1:0] sh;
    logic [CELLS_PER_IO-1:0] upd;
  } cell_state_t;
  cell_state_t state_ff;
  cell_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (capture_en) begin
      nxt_state.sh = cap_val;
    end else if (shift_en) begin
      nxt_state.sh = {scan_in, state_ff.sh[CELLS_PER_IO-1:1]};
    end
    if (update_en) begin
      nxt_state.upd = state_ff.sh;
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign scan_out = state_ff.sh[0];
  assign upd_val = state_ff.upd;
endmodule

/* File: src/scan_instr_decode.sv */
`timescale 1ns/10ps
// Summary of operation
// - Code 00111 drives core-side inputs from the boundary update stage.
// - Code 01000 shifts out the user code; 01001 shifts the identification word.
// - Code 01010 disables pads and selects bypass; 11111 only selects bypass.
// - Code 01100 steps start-up on each test clock in Run-Test/Idle when that clock is chosen.
// - Before configuration all public codes work except the two user codes.
// - After configuration public codes work, plus user codes the loaded design installed.
// - During configuration only sample/preload and bypass are honoured.
// - Configuration bytes may be written and read back through the scan port.
// - Reset, update and shift state outputs serve internal user scan chains.
// - Each io_block carries three boundary cells in the scan chain.
// - Standard sixteen-state controller plus instruction register selecting the data register.
// - Start-up runs eight steps before the design becomes active.
module scan_instr_decode
  import scan_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic cfg_busy,
  input wire logic cfg_done,
  input wire logic user_instr_installed,
  input wire logic [ID_W-1:0] user_code,
  output logic [BYTE_W-1:0] cfg_wr_data,
  output logic cfg_wr_valid,
  output logic cfg_rd_req,
  input wire logic [BYTE_W-1:0] cfg_rd_data,
  input wire logic startup_clock_source,
  output logic [2:0] startup_phase,
  output logic design_active,
  output logic user_sel_a,
  output logic user_sel_b,
  input wire logic user_tdo_a,
  input wire logic user_tdo_b,
  output logic user_reset,
  output logic user_update,
  output logic user_shift,
  input wire logic [IO_BLOCKS-1:0] core_out,
  input wire logic [IO_BLOCKS-1:0] core_oe,
  output logic [IO_BLOCKS-1:0] core_in,
  input wire logic [IO_BLOCKS-1:0] pad_in,
  output logic [IO_BLOCKS-1:0] pad_out,
  output logic [IO_BLOCKS-1:0] pad_oe
);
  typedef struct packed {
    logic rst_meta;
    logic rst;
    tap_state_t tap;
    instr_t ir_sh;
    instr_t ir;
    logic [ID_W-1:0] dr_sh;
    logic byp;
    logic [2:0] bit_cnt;
    logic [BYTE_W-1:0] byte_sh;
    logic [BYTE_W-1:0] wr_hold;
    logic wr_tgl;
    logic rd_tgl;
    logic step_tgl;
    logic u_rst;
    logic u_upd;
    logic u_sh;
    logic oe;
  } tck_state_t;

  typedef struct packed {
    logic primed;
    logic wr_seen;
    logic rd_seen;
    logic step_seen;
    logic [BYTE_W-1:0] rd_hold;
    logic [BYTE_W-1:0] wr_data;
    logic wr_valid;
    logic rd_req;
    logic [2:0] phase;
    logic active;
  } core_state_t;

  tck_state_t t_ff;
  tck_state_t nxt_t;
  core_state_t c_ff;
  core_state_t nxt_c;
  logic [2:0] cfg_sync;
  logic [2:0] tgl_sync;
  logic src_tck_sync;
  cfg_phase_t cfg_phase;
  logic [IO_BLOCKS-1:0] pad_sync;
  logic [2*IO_BLOCKS-1:0] core_sync;
  logic [IO_BLOCKS:0] chain;
  logic [CELLS_PER_IO-1:0] cap_val [IO_BLOCKS];
  logic [CELLS_PER_IO-1:0] upd_val [IO_BLOCKS];
  logic mode_extest;
  logic mode_intest;
  logic mode_highz;
  logic mode_bsr;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    unique case (s)
      TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: return m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: return m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  function automatic logic instr_ok(input instr_t c, input cfg_phase_t p, input logic uok);
    logic pub;
    logic usr;
    pub = c inside {INS_EXTEST, INS_SAMPLE, INS_CFG_OUT, INS_CFG_IN, INS_INTEST,
                    INS_USERCODE, INS_IDCODE, INS_HIGHZ, INS_STARTUP, INS_BYPASS};
    usr = (c == INS_USER_A) || (c == INS_USER_B);
    unique case (p)
      CFG_BLANK: return pub;
      CFG_LOADING: return (c == INS_SAMPLE) || (c == INS_BYPASS);
      CFG_READY: return pub || (usr && uok);
      default: return 1'b0;
    endcase
  endfunction

  scan_sync #(.W(3)) u_cfg_sync (
    .clk(tck),
    .async_in({user_instr_installed, cfg_done, cfg_busy}),
    .sync_out(cfg_sync)
  );

  scan_sync #(.W(IO_BLOCKS)) u_pad_sync (
    .clk(tck),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // Core drive levels are captured in the test clock domain, so they are resynchronised first.
  scan_sync #(.W(2*IO_BLOCKS)) u_core_sync (
    .clk(tck),
    .async_in({core_oe, core_out}),
    .sync_out(core_sync)
  );

  scan_sync #(.W(3)) u_tgl_sync (
    .clk(core_clk),
    .async_in({t_ff.step_tgl, t_ff.rd_tgl, t_ff.wr_tgl}),
    .sync_out(tgl_sync)
  );

  scan_sync #(.W(1)) u_src_sync (
    .clk(core_clk),
    .async_in(startup_clock_source),
    .sync_out(src_tck_sync)
  );

  assign cfg_phase = cfg_sync[1] ? CFG_READY : (cfg_sync[0] ? CFG_LOADING : CFG_BLANK);
  assign mode_intest = (t_ff.ir == INS_INTEST);
  assign mode_extest = (t_ff.ir == INS_EXTEST);
  assign mode_highz = (t_ff.ir == INS_HIGHZ);
  assign mode_bsr = mode_extest || mode_intest || (t_ff.ir == INS_SAMPLE);

  // Three cells per io_block in one chain.
  assign chain[0] = tdi;
  for (genvar g = 0; g < IO_BLOCKS; g++) begin : g_io
    assign cap_val[g] = {core_sync[IO_BLOCKS+g], core_sync[g], pad_sync[g]};
    scan_io_cells u_cells (
      .tck(tck),
      .tck_rst(t_ff.rst),
      .capture_en(mode_bsr && (t_ff.tap == TAP_CAP_DR)),
      .shift_en(mode_bsr && (t_ff.tap == TAP_SH_DR)),
      .update_en(mode_bsr && (t_ff.tap == TAP_UPD_DR)),
      .scan_in(chain[g]),
      .cap_val(cap_val[g]),
      .scan_out(chain[g+1]),
      .upd_val(upd_val[g])
    );
    assign pad_out[g] = mode_extest ? upd_val[g][CELL_OUT] : core_out[g];
    assign pad_oe[g] = mode_highz ? 1'b0 : (mode_extest ? upd_val[g][CELL_OE] : core_oe[g]);
    assign core_in[g] = mode_intest ? upd_val[g][CELL_IN] : pad_in[g];
  end

  always_comb begin
    nxt_t = t_ff;
    nxt_t.rst_meta = reset;
    nxt_t.rst = t_ff.rst_meta;
    nxt_t.tap = tap_next(t_ff.tap, tms);
    unique case (t_ff.tap)
      TAP_RESET: begin
        nxt_t.ir = INS_IDCODE;
      end
      TAP_CAP_IR: begin
        nxt_t.ir_sh = IR_CAPTURE;
      end
      TAP_SH_IR: begin
        nxt_t.ir_sh = {tdi, t_ff.ir_sh[IR_W-1:1]};
      end
      TAP_UPD_IR: begin
        nxt_t.ir = instr_ok(t_ff.ir_sh, cfg_phase, cfg_sync[2]) ? t_ff.ir_sh : INS_BYPASS;
      end
      TAP_CAP_DR: begin
        nxt_t.bit_cnt = '0;
        nxt_t.byp = 1'b0;
        if (t_ff.ir == INS_IDCODE) begin
          nxt_t.dr_sh = ID_VALUE;
        end else if (t_ff.ir == INS_USERCODE) begin
          nxt_t.dr_sh = user_code;
        end
        // Readback fetch of the next byte.
        if (t_ff.ir == INS_CFG_OUT) begin
          nxt_t.byte_sh = c_ff.rd_hold;
          nxt_t.rd_tgl = !t_ff.rd_tgl;
        end
      end
      TAP_SH_DR: begin
        nxt_t.byp = tdi;
        nxt_t.dr_sh = {tdi, t_ff.dr_sh[ID_W-1:1]};
        nxt_t.bit_cnt = t_ff.bit_cnt + 3'h1;
        nxt_t.byte_sh = {t_ff.byte_sh[BYTE_W-2:0], tdi};
        // Configuration byte hand-off, most significant bit first.
        if (t_ff.ir == INS_CFG_IN && t_ff.bit_cnt == BIT_LAST) begin
          nxt_t.wr_hold = {t_ff.byte_sh[BYTE_W-2:0], tdi};
          nxt_t.wr_tgl = !t_ff.wr_tgl;
        end
        if (t_ff.ir == INS_CFG_OUT && t_ff.bit_cnt == BIT_LAST) begin
          nxt_t.byte_sh = c_ff.rd_hold;
          nxt_t.rd_tgl = !t_ff.rd_tgl;
        end
      end
      TAP_IDLE: begin
        // One start-up step per test clock.
        if (t_ff.ir == INS_STARTUP) begin
          nxt_t.step_tgl = !t_ff.step_tgl;
        end
      end
      default: begin
      end
    endcase
    nxt_t.u_rst = (nxt_t.tap == TAP_RESET);
    nxt_t.u_upd = (nxt_t.tap == TAP_UPD_DR);
    nxt_t.u_sh = (nxt_t.tap == TAP_SH_DR);
    nxt_t.oe = (nxt_t.tap == TAP_SH_DR) || (nxt_t.tap == TAP_SH_IR);
    // While the resynchronised reset stands, all but the reset chain is cleared; ir loads the identification code and u_rst is set.
    if (t_ff.rst) begin
      nxt_t = '0;
      nxt_t.rst_meta = reset;
      nxt_t.rst = t_ff.rst_meta;
      nxt_t.ir = INS_IDCODE;
      nxt_t.u_rst = 1'b1;
    end
  end

  always_ff @(posedge tck) begin
    t_ff <= nxt_t;
  end

  always_comb begin
    tdo = t_ff.byp;
    if (t_ff.tap == TAP_SH_IR) begin
      tdo = t_ff.ir_sh[0];
    end else if (t_ff.ir == INS_IDCODE || t_ff.ir == INS_USERCODE) begin
      tdo = t_ff.dr_sh[0];
    end else if (t_ff.ir == INS_CFG_OUT || t_ff.ir == INS_CFG_IN) begin
      tdo = t_ff.byte_sh[BYTE_W-1];
    end else if (mode_bsr) begin
      tdo = chain[IO_BLOCKS];
    end else if (t_ff.ir == INS_USER_A) begin
      tdo = user_tdo_a;
    end else if (t_ff.ir == INS_USER_B) begin
      tdo = user_tdo_b;
    end
  end

  assign tdo_oe = t_ff.oe;
  assign user_sel_a = (t_ff.ir == INS_USER_A);
  assign user_sel_b = (t_ff.ir == INS_USER_B);
  assign user_reset = t_ff.u_rst;
  assign user_update = t_ff.u_upd;
  assign user_shift = t_ff.u_sh;

  always_comb begin
    nxt_c = c_ff;
    nxt_c.wr_valid = 1'b0;
    nxt_c.rd_req = 1'b0;
    nxt_c.wr_seen = tgl_sync[0];
    nxt_c.rd_seen = tgl_sync[1];
    nxt_c.step_seen = tgl_sync[2];
    // Write byte pulse and readback prefetch.
    if (tgl_sync[0] != c_ff.wr_seen) begin
      nxt_c.wr_valid = 1'b1;
      nxt_c.wr_data = t_ff.wr_hold;
    end
    if (!c_ff.primed || tgl_sync[1] != c_ff.rd_seen) begin
      nxt_c.primed = 1'b1;
      nxt_c.rd_req = 1'b1;
      nxt_c.rd_hold = cfg_rd_data;
    end
    // Eight start-up steps, core clock or scan steps.
    if (!cfg_done) begin
      nxt_c.phase = '0;
      nxt_c.active = 1'b0;
    end else if (!c_ff.active) begin
      if (!src_tck_sync || tgl_sync[2] != c_ff.step_seen) begin
        nxt_c.phase = c_ff.phase + 3'h1;
        nxt_c.active = (c_ff.phase == STARTUP_LAST);
        if (c_ff.phase == STARTUP_LAST) begin
          nxt_c.phase = c_ff.phase;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      c_ff <= '0;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign cfg_wr_data = c_ff.wr_data;
  assign cfg_wr_valid = c_ff.wr_valid;
  assign cfg_rd_req = c_ff.rd_req;
  assign startup_phase = c_ff.phase;
  assign design_active = c_ff.active;

  AST_INTEST_DRIVE: assert property (@(posedge tck) disable iff (t_ff.rst)
    mode_intest |-> core_in[0] == upd_val[0][CELL_IN]) else $error("intest core input wrong");
  AST_ID_CAPTURE: assert property (@(posedge tck) disable iff (t_ff.rst)
    (t_ff.tap == TAP_CAP_DR && t_ff.ir == INS_IDCODE) |=> t_ff.dr_sh == ID_VALUE)
    else $error("identification word not captured");
  AST_HIGHZ_PADS: assert property (@(posedge tck) disable iff (t_ff.rst)
    mode_highz |-> pad_oe == '0) else $error("pads driven under high-z");
  AST_STARTUP_STEP: assert property (@(posedge tck) disable iff (t_ff.rst)
    (t_ff.tap == TAP_IDLE && t_ff.ir == INS_STARTUP) |=> t_ff.step_tgl != $past(t_ff.step_tgl))
    else $error("start-up step missed");
  AST_USER_BLOCKED: assert property (@(posedge tck) disable iff (t_ff.rst)
    (t_ff.tap == TAP_UPD_IR && cfg_phase == CFG_BLANK && t_ff.ir_sh == INS_USER_A)
    |=> t_ff.ir == INS_BYPASS) else $error("user code taken before configuration");
  AST_USER_ALLOWED: assert property (@(posedge tck) disable iff (t_ff.rst)
    (t_ff.tap == TAP_UPD_IR && cfg_phase == CFG_READY && cfg_sync[2] && t_ff.ir_sh == INS_USER_B)
    |=> t_ff.ir == INS_USER_B) else $error("installed user code refused");
  AST_LOADING_LIMIT: assert property (@(posedge tck) disable iff (t_ff.rst)
    (t_ff.tap == TAP_UPD_IR && cfg_phase == CFG_LOADING && t_ff.ir_sh == INS_IDCODE)
    |=> t_ff.ir == INS_BYPASS) else $error("code taken during configuration");
  AST_WR_PULSE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_wr_valid |=> !cfg_wr_valid) else $error("write strobe longer than one cycle");
  AST_USER_SHIFT: assert property (@(posedge tck) disable iff (t_ff.rst)
    user_shift == (t_ff.tap == TAP_SH_DR)) else $error("shift state output wrong");
  AST_TAP_RESET: assert property (@(posedge tck) disable iff (t_ff.rst)
    tms [*5] |=> t_ff.tap == TAP_RESET) else $error("controller not reset by five tms");
  AST_STARTUP_LEN: assert property (@(posedge core_clk) disable iff (reset)
    $rose(design_active) |-> $past(startup_phase) == STARTUP_LAST)
    else $error("start-up ended early");
endmodule

/* File: bench/scan_tap_model.sv */
`timescale 1ns/10ps
// Behavioural test-port controller that drives the scan link with a gated test clock.
module scan_tap_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // Controller supplies clocks.
  // One test clock period; the clock stands low between calls and the data line rests high.
  task automatic tick(input logic m, input logic d);
    #11;
    tms = m;
    tdi = d;
    #13 tck = 1'b1;
    #24 tck = 1'b0;
    tdi = 1'b1;
  endtask

  task automatic idle(input int n);
    repeat (n) tick(1'b0, 1'b1);
  endtask

  task automatic tlr();
    repeat (5) tick(1'b1, 1'b1);
  endtask

  // Standard state walk.
  // Shifts n bits LSB first from Run-Test/Idle and returns there; an undriven output reads z.
  task automatic shift(input logic ir, input int n, input logic [63:0] din,
    output logic [63:0] dout);
    dout = '0;
    tick(1'b1, 1'b1);
    if (ir)
      tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      dout[i] = tdo_oe ? tdo : 1'bz;
      tick(i == n - 1, din[i]);
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
endmodule

/* File: bench/scan_instr_decode_tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the scan instruction decode block.
module scan_instr_decode_tb;
  import scan_pkg::*;
  localparam instr_t code_tab [11] = '{INS_EXTEST, INS_SAMPLE, INS_USER_A, INS_USER_B,
    INS_CFG_OUT, INS_CFG_IN, INS_INTEST, INS_USERCODE, INS_IDCODE, INS_HIGHZ, INS_BYPASS};
  localparam int chain_len = IO_BLOCKS * CELLS_PER_IO;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, cfg_busy, cfg_done, user_instr_installed;
  logic startup_clock_source, design_active, user_sel_a, user_sel_b, user_tdo_a, user_tdo_b;
  logic user_reset, user_update, user_shift, cfg_wr_valid, cfg_rd_req;
  logic [ID_W-1:0] user_code;
  logic [BYTE_W-1:0] cfg_wr_data, cfg_rd_data;
  logic [BYTE_W-1:0] rd_idx = 8'h00;
  logic [2:0] startup_phase;
  logic [IO_BLOCKS-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [BYTE_W-1:0] rd_q[$], wr_q[$];
  int num_errors = 0;
  int checked = 0;
  int sh_cnt = 0;
  int up_cnt = 0;

  scan_instr_decode u_scan_instr_decode (.core_clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .cfg_busy, .cfg_done, .user_instr_installed, .user_code, .cfg_wr_data, .cfg_wr_valid,
    .cfg_rd_req, .cfg_rd_data, .startup_clock_source, .startup_phase, .design_active,
    .user_sel_a, .user_sel_b, .user_tdo_a, .user_tdo_b, .user_reset, .user_update,
    .user_shift, .core_out, .core_oe, .core_in, .pad_in, .pad_out, .pad_oe);
  scan_tap_model u_scan_tap_model (.tck, .tms, .tdi, .tdo, .tdo_oe);

  always #2 core_clk = ~core_clk;

  // Readback source hands out a new byte each time one is requested.
  assign cfg_rd_data = rd_idx * 8'h1d + 8'h3c;

  always @(posedge core_clk) begin
    if (cfg_rd_req) begin
      rd_q.push_back(cfg_rd_data);
      rd_idx <= rd_idx + 8'h01;
    end
    if (cfg_wr_valid)
      wr_q.push_back(cfg_wr_data);
  end

  always @(negedge tck) begin
    sh_cnt += int'(user_shift);
    up_cnt += int'(user_update);
  end

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] b);
    return {<<{b}};
  endfunction

  // Phase 0 blank, 1 loading, 2 loaded without user codes, 3 loaded with user codes.
  function automatic instr_t eff_code(input instr_t c, input int ph);
    if (!(c inside {code_tab, INS_STARTUP}))
      return INS_BYPASS;
    if (ph == 1 && !(c inside {INS_SAMPLE, INS_BYPASS}))
      return INS_BYPASS;
    if (ph != 3 && c inside {INS_USER_A, INS_USER_B})
      return INS_BYPASS;
    return c;
  endfunction

  function automatic instr_t rsv();
    instr_t r;
    r = INS_STARTUP;
    while (r inside {code_tab, INS_STARTUP})
      r = instr_t'($urandom);
    return r;
  endfunction

  task automatic run_code(input instr_t c, input int ph);
    instr_t e;
    logic [63:0] o, d;
    e = eff_code(c, ph);
    d = {$urandom, $urandom};
    @(negedge core_clk);
    {user_tdo_a, user_tdo_b, core_out, core_oe, pad_in} = 14'($urandom);
    u_scan_tap_model.shift(1'b1, IR_W, 64'(c), o);
    check("ir capture", 64'(IR_CAPTURE), o);
    check("user select", 64'({e == INS_USER_A, e == INS_USER_B}),
      64'({user_sel_a, user_sel_b}));
    if (e == INS_HIGHZ)
      check("pads off", 64'h0, 64'(pad_oe));
    u_scan_tap_model.shift(1'b0, 33, d, o);
    if (e inside {INS_BYPASS, INS_HIGHZ})
      check("bypass", 64'({d[31:0], 1'b0}), o);
    if (e == INS_IDCODE)
      check("id word", 64'({d[0], ID_VALUE}), o);
    if (e == INS_USERCODE)
      check("user code", 64'({d[0], user_code}), o);
    if (e inside {INS_USER_A, INS_USER_B})
      check("user chain", 64'({32{e == INS_USER_A ? user_tdo_a : user_tdo_b}}), o >> 1);
  endtask

  task automatic boundary(input logic v);
    logic [63:0] o;
    @(negedge core_clk);
    {core_out, core_oe, pad_in} = {chain_len{v}};
    u_scan_tap_model.shift(1'b1, IR_W, 64'(INS_SAMPLE), o);
    u_scan_tap_model.shift(1'b0, chain_len + 1, {64{~v}}, o);
    check("boundary chain", 64'({~v, {chain_len{v}}}), o);
    u_scan_tap_model.shift(1'b1, IR_W, 64'(INS_INTEST), o);
    repeat (10) @(negedge core_clk);
    check("core side inputs", 64'({IO_BLOCKS{~v}}), 64'(core_in));
  endtask

  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    logic [63:0] o;
    logic [15:0] b;
    int n;
    void'($urandom(7831));
    {cfg_busy, cfg_done, user_instr_installed, user_tdo_a, user_tdo_b} = 5'h00;
    startup_clock_source = 1'b1;
    user_code = $urandom;
    {core_out, core_oe, pad_in} = 12'h000;
    repeat (2) @(negedge core_clk);
    u_scan_tap_model.tlr();
    @(negedge core_clk);
    reset = 1'b0;
    u_scan_tap_model.tlr();
    check("reset state", 64'h1, 64'(user_reset));
    u_scan_tap_model.idle(2);
    check("leave reset", 64'h0, 64'(user_reset));
    n = sh_cnt + 1000 * up_cnt;
    u_scan_tap_model.shift(1'b0, 33, 64'h1, o);
    check("id word", 64'({1'b1, ID_VALUE}), o);
    check("shift update", 64'(1033), 64'(sh_cnt + 1000 * up_cnt - n));
    for (int ph = 0; ph < 4; ph++) begin
      @(negedge core_clk);
      cfg_busy = (ph == 1);
      cfg_done = (ph >= 2);
      user_instr_installed = (ph == 3);
      repeat (10) @(negedge core_clk);
      for (int k = 0; k < 12; k++)
        run_code(k < 11 ? code_tab[k] : rsv(), ph);
    end
    u_scan_tap_model.shift(1'b1, IR_W, 64'(INS_CFG_OUT), o);
    n = rd_q.size();
    u_scan_tap_model.shift(1'b0, 16, 64'h0, o);
    check("readback", 64'({rev8(rd_q[n]), rev8(rd_q[n-1])}), o);
    b = 16'($urandom);
    wr_q.delete();
    u_scan_tap_model.shift(1'b1, IR_W, 64'(INS_CFG_IN), o);
    u_scan_tap_model.shift(1'b0, 16, 64'({rev8(b[15:8]), rev8(b[7:0])}), o);
    repeat (10) @(negedge core_clk);
    check("write count", 64'h2, 64'(wr_q.size()));
    check("write data", 64'(b), 64'({wr_q[1], wr_q[0]}));
    boundary(1'b1);
    boundary(1'b0);
    u_scan_tap_model.shift(1'b1, IR_W, 64'(INS_STARTUP), o);
    u_scan_tap_model.idle(7);
    repeat (20) @(negedge core_clk);
    check("early start", 64'({STARTUP_LAST, 1'b0}),
      64'({startup_phase, design_active}));
    u_scan_tap_model.idle(1);
    repeat (20) @(negedge core_clk);
    check("design active", 64'h1, 64'(design_active));
    // Second start-up, this time stepped by the core clock.
    @(negedge core_clk);
    cfg_done = 1'b0;
    startup_clock_source = 1'b0;
    repeat (5) @(negedge core_clk);
    check("start held", 64'h0, 64'(design_active));
    cfg_done = 1'b1;
    repeat (20) @(negedge core_clk);
    check("core clock start", 64'h1, 64'(design_active));
    tally_and_finish();
  end
endmodule
